/* File: common/stepper_spi_pkg.sv */
package stepper_spi_pkg;

	// Link framing
	localparam int        BITS_PER_BYTE = 8;
	localparam int        FRAME_BITS    = 16;
	localparam logic [4:0] FRAME_DONE   = 5'h10;
	localparam logic [4:0] FRAME_OVER   = 5'h11;
	localparam logic [4:0] BYTE1_DONE   = 5'h08;

	// First byte: command bit and register address
	localparam int         CMD_WRITE_BIT = 7;
	localparam int         ADDR_MSB      = 4;
	localparam logic [4:0] ADDR_WDCTL    = 5'h00;
	localparam logic [4:0] ADDR_STATUS0  = 5'h04;

	// Watchdog control register layout
	localparam int         WD_ARM_BIT     = 7;
	localparam int         WD_INT_MSB     = 6;
	localparam int         WD_INT_LSB     = 3;
	localparam logic [7:0] WD_USED_MASK   = 8'hf8;
	localparam logic [7:0] WDCTL_RESET    = 8'h00;
	localparam logic [7:0] STATUS_RESET   = 8'h00;

	// Status register 0 layout
	localparam int ST_TW_BIT     = 6;
	localparam int ST_CPFAIL_BIT = 5;
	localparam int ST_OPENX_BIT  = 3;
	localparam int ST_OPENY_BIT  = 2;

	// Charge pump start-up, longest time rounds down
	localparam int CLOCK_MHZ          = 100;
	localparam int CP_STARTUP_US      = 2000;
	localparam int CP_STARTUP_CYCLES  = CP_STARTUP_US * CLOCK_MHZ;

	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_ACTIVE = 1'b1
	} link_state_t;

endpackage

/* File: core/pin_sync3.sv */
`timescale 1ns/1ns
module pin_sync3 #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Pins in, filtered levels out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_t;

	sync_t r;
	sync_t n;

	always_comb begin
		n    = r;
		n.s1 = d;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// Level moves only once two late stages agree
		for (int i = 0; i < WIDTH; i++) begin
			if (r.s2[i] == r.s3[i]) begin
				n.out[i] = r.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL,
				out: RESET_VAL};
		end else begin
			r <= n;
		end
	end

	assign q = r.out;

endmodule

/* File: core/stepper_spi_slave.sv */
`timescale 1ns/1ns
module stepper_spi_slave
	import stepper_spi_pkg::*;
#(
	parameter int OVC_WIDTH  = 4,
	parameter int OPEN_WIDTH = 2,
	parameter int CP_STARTUP = CP_STARTUP_CYCLES
) (
	// Clock and reset
	input  wire logic                  CLOCK,
	input  wire logic                  RESETN,
	input  wire logic                  HARD_RESET_IN,
	// Serial link pins
	input  wire logic                  SCLK_IN,
	input  wire logic                  SELECT_N,
	input  wire logic                  SDI_IN,
	output logic                       SDO_O,
	output logic                       SDO_OE,
	// Diagnostic flags
	input  wire logic                  THERMAL_WARNING_FLAG,
	input  wire logic                  THERMAL_SHUTDOWN_FLAG,
	input  wire logic [OVC_WIDTH-1:0]  OVERCURRENT_X_FLAGS,
	input  wire logic [OVC_WIDTH-1:0]  OVERCURRENT_Y_FLAGS,
	input  wire logic [OPEN_WIDTH-1:0] OPEN_COIL_FLAGS,
	input  wire logic                  CHARGE_PUMP_LOW,
	// Fault pin, open drain
	output logic                       FAULT_OUT_N_O,
	output logic                       FAULT_OUT_N_OE,
	// Watchdog control and charge pump fail
	output logic                       WATCHDOG_ARM_BIT,
	output logic [3:0]                 WATCHDOG_INTERVAL,
	output logic                       WATCHDOG_KICK,
	output logic                       WATCHDOG_FLAG_CLEAR,
	output logic                       CHARGE_PUMP_FAIL
);

	localparam int CPW = $clog2(CP_STARTUP + 1);
	// Hard reset, two thermal flags and pump low, then the flag vectors
	localparam int FLW = 4 + 2 * OVC_WIDTH + OPEN_WIDTH;
	localparam logic [CPW-1:0] CP_LOAD = CPW'(CP_STARTUP);

	typedef struct packed {
		link_state_t    st;
		logic [4:0]     bitcnt;
		logic [15:0]    rx;
		logic [7:0]     tx;
		logic           sclk_q;
		logic           cs_q;
		logic           sdo_oe;
		logic           fault_oe;
		logic [7:0]     wdctl;
		logic           kick;
		logic           wdclr;
		logic [CPW-1:0] cp_cnt;
	} state_t;

	state_t r;
	state_t n;

	logic [2:0]     link_s;
	logic           sclk_s;
	logic           cs_n_s;
	logic           sdi_s;
	logic           hard_s;
	logic           tw_s;
	logic           tsd_s;
	logic           cplow_s;
	logic [OVC_WIDTH-1:0]  ovcx_s;
	logic [OVC_WIDTH-1:0]  ovcy_s;
	logic [OPEN_WIDTH-1:0] open_s;
	logic           cpfail;
	logic           fault_any;
	logic [7:0]     status0;
	logic           sclk_rise;
	logic           sclk_fall;
	logic           cs_fall;

	pin_sync3 #(
		.WIDTH     (3),
		.RESET_VAL (3'h2)
	) link_sync (
		.clk    (CLOCK),
		.resetn (RESETN),
		.d      ({SCLK_IN, SELECT_N, SDI_IN}),
		.q      (link_s)
	);

	pin_sync3 #(
		.WIDTH     (FLW),
		.RESET_VAL ('0)
	) flag_sync (
		.clk    (CLOCK),
		.resetn (RESETN),
		.d      ({HARD_RESET_IN, THERMAL_WARNING_FLAG,
			THERMAL_SHUTDOWN_FLAG, CHARGE_PUMP_LOW,
			OVERCURRENT_X_FLAGS, OVERCURRENT_Y_FLAGS,
			OPEN_COIL_FLAGS}),
		.q      ({hard_s, tw_s, tsd_s, cplow_s, ovcx_s, ovcy_s, open_s})
	);

	assign sclk_s = link_s[2];
	assign cs_n_s = link_s[1];
	assign sdi_s  = link_s[0];

	function automatic logic [4:0] addr_of(input logic [7:0] cmd);
		return cmd[ADDR_MSB:0];
	endfunction

	function automatic logic [7:0] reg_read(input logic [4:0] addr,
		input logic [7:0] wdctl, input logic [7:0] st0);
		case (addr)
			ADDR_WDCTL:   reg_read = wdctl;
			ADDR_STATUS0: reg_read = st0;
			default:      reg_read = STATUS_RESET;
		endcase
	endfunction

	// Pump counts from power-on only; hard reset leaves it running
	assign cpfail    = (r.cp_cnt != '0) | cplow_s;
	assign fault_any = tw_s | tsd_s | (|ovcx_s) | (|ovcy_s)
		| (|open_s) | cpfail;

	always_comb begin
		status0                = STATUS_RESET;
		status0[ST_TW_BIT]     = tw_s;
		status0[ST_CPFAIL_BIT] = cpfail;
		status0[ST_OPENX_BIT]  = open_s[0];
		status0[ST_OPENY_BIT]  = open_s[OPEN_WIDTH-1];
	end

	assign sclk_rise = sclk_s & ~r.sclk_q;
	assign sclk_fall = ~sclk_s & r.sclk_q;
	assign cs_fall   = r.cs_q & ~cs_n_s;

	always_comb begin
		n          = r;
		n.kick     = 1'b0;
		n.wdclr    = 1'b0;
		n.sclk_q   = sclk_s;
		n.cs_q     = cs_n_s;
		n.fault_oe = fault_any;
		if (r.cp_cnt != '0) begin
			n.cp_cnt = r.cp_cnt - 1'b1;
		end
		case (r.st)
			ST_IDLE: begin
				n.sdo_oe = 1'b0;
				// Transfers start only from the master's select
				if (cs_fall) begin
					n.st     = ST_ACTIVE;
					n.bitcnt = '0;
					n.tx     = status0;
					n.sdo_oe = ~status0[7];
				end
			end
			ST_ACTIVE: begin
				if (cs_n_s) begin
					n.st     = ST_IDLE;
					n.sdo_oe = 1'b0;
					if (r.bitcnt == FRAME_DONE && r.rx[15-7+CMD_WRITE_BIT]
						&& addr_of(r.rx[15:8]) == ADDR_WDCTL) begin
						n.wdctl = r.rx[7:0] & WD_USED_MASK;
						n.kick  = r.rx[WD_ARM_BIT];
						n.wdclr = ~r.rx[WD_ARM_BIT];
					end
				end else if (sclk_rise) begin
					n.rx = {r.rx[14:0], sdi_s};
					// Saturate past a full frame so extra clocks void it
					if (r.bitcnt != FRAME_OVER) begin
						n.bitcnt = r.bitcnt + 1'b1;
					end
				end else if (sclk_fall) begin
					if (r.bitcnt == BYTE1_DONE) begin
						n.tx = reg_read(addr_of(r.rx[7:0]), r.wdctl,
							status0);
					end else begin
						n.tx = {r.tx[6:0], 1'b0};
					end
					n.sdo_oe = ~n.tx[7];
				end
			end
			default: begin
				n.st     = ST_IDLE;
				n.sdo_oe = 1'b0;
			end
		endcase
		if (hard_s) begin
			n.st     = ST_IDLE;
			n.bitcnt = '0;
			n.sdo_oe = 1'b0;
			n.wdctl  = WDCTL_RESET;
			n.kick   = 1'b0;
			n.wdclr  = 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			r <= '{st: ST_IDLE, bitcnt: 5'h00, rx: 16'h0000,
				tx: 8'h00, sclk_q: 1'b0, cs_q: 1'b1, sdo_oe: 1'b0,
				fault_oe: 1'b0, wdctl: WDCTL_RESET, kick: 1'b0,
				wdclr: 1'b0, cp_cnt: CP_LOAD};
		end else begin
			r <= n;
		end
	end

	assign SDO_O               = 1'b0;
	assign SDO_OE              = r.sdo_oe;
	assign FAULT_OUT_N_O       = 1'b0;
	assign FAULT_OUT_N_OE      = r.fault_oe;
	assign WATCHDOG_ARM_BIT    = r.wdctl[WD_ARM_BIT];
	assign WATCHDOG_INTERVAL   = r.wdctl[WD_INT_MSB:WD_INT_LSB];
	assign WATCHDOG_KICK       = r.kick;
	assign WATCHDOG_FLAG_CLEAR = r.wdclr;
	assign CHARGE_PUMP_FAIL    = cpfail;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	deselect_release_a: assert property (
		cs_n_s |=> !SDO_OE)
		else $error("output driven while deselected");

	slave_only_a: assert property (
		(r.st == ST_IDLE && !cs_fall) |=> !SDO_OE)
		else $error("output driven without a started transfer");

	fault_drive_a: assert property (
		fault_any |=> FAULT_OUT_N_OE)
		else $error("fault pin not pulled low");

	fault_quiet_a: assert property (
		!fault_any |=> !FAULT_OUT_N_OE)
		else $error("fault pin low without a flag");

	pump_start_a: assert property (
		(r.cp_cnt != '0) |-> CHARGE_PUMP_FAIL)
		else $error("pump fail dropped during start-up");

	write_commit_a: assert property (
		(r.st == ST_ACTIVE && cs_n_s && !hard_s
		&& r.bitcnt == FRAME_DONE && r.rx[15]
		&& r.rx[12:8] == ADDR_WDCTL)
		|=> (r.wdctl == ($past(r.rx[7:0]) & WD_USED_MASK)))
		else $error("full write not committed");

	short_write_a: assert property (
		(r.bitcnt != FRAME_DONE && !hard_s) |=> $stable(r.wdctl))
		else $error("register changed on incomplete transfer");

	unused_zero_a: assert property (
		r.wdctl[2:0] == 3'h0)
		else $error("unused watchdog bits set");

	arm_pulse_a: assert property (
		WATCHDOG_KICK |-> WATCHDOG_ARM_BIT ##1 !WATCHDOG_KICK)
		else $error("watchdog kick wrong");

	hard_clear_a: assert property (
		hard_s |=> (r.wdctl == WDCTL_RESET && !SDO_OE))
		else $error("hard reset did not clear");

	bit_count_a: assert property (
		(r.st == ST_ACTIVE && !cs_n_s && sclk_rise && !hard_s
		&& r.bitcnt < FRAME_OVER) |=> r.bitcnt == $past(r.bitcnt) + 5'h01)
		else $error("input bit not counted");

endmodule

/* File: verif/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model (
	// Serial link
	input  wire logic sdo_line,
	output logic      sclk,
	output logic      sel_n,
	output logic      sdi,
	// Received word
	output logic [15:0] rx,
	output logic        rx_done
);
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		sdi = 1'b0;
		rx = 16'h0000;
		rx_done = 1'b0;
	end

	// Data sampled late in the high phase to absorb the slave's sync delay
	task automatic frame(input logic [15:0] tx, input int n);
		sel_n = 1'b0;
		#203;
		for (int i = 0; i < n; i++) begin
			sdi = (i < 16) ? tx[15 - i] : ~sdi;
			#62 sclk = 1'b1;
			#62 rx = {rx[14:0], sdo_line};
			#1 sclk = 1'b0;
		end
		#150 sel_n = 1'b1;
		// Released line must not keep its last value
		sdi = ~sdi;
		rx_done = 1'b1;
		#10 rx_done = 1'b0;
		#3000;
	endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top
	import stepper_spi_pkg::*;
;
	logic        CLOCK = 1'b0;
	logic        RESETN = 1'b0;
	logic        HARD_RESET_IN = 1'b0;
	logic [12:0] fl = 13'h0000;
	logic        cp_up = 1'b0;
	wire logic   sclk, sel_n, sdi, rx_done;
	wire logic [15:0] rx;
	logic        sdo_o, sdo_oe, flt_o, flt_oe, arm, kick, wclr, cpf;
	logic [3:0]  ivl;
	wire logic   sdo_line = sdo_oe ? sdo_o : 1'b1;
	int          num_errors = 0;
	int          comparisons = 0;
	logic [31:0] rx_q[$];
	logic [6:0]  ev_q[$];
	logic [31:0] rx_t;
	logic [7:0]  d;

	always #5 CLOCK = ~CLOCK;

	stepper_spi_slave #(.OVC_WIDTH(4), .OPEN_WIDTH(2), .CP_STARTUP(50))
	stepper_spi_slave_inst (
		.CLOCK, .RESETN, .HARD_RESET_IN,
		.SCLK_IN(sclk), .SELECT_N(sel_n), .SDI_IN(sdi),
		.SDO_O(sdo_o), .SDO_OE(sdo_oe),
		.THERMAL_WARNING_FLAG(fl[12]), .THERMAL_SHUTDOWN_FLAG(fl[11]),
		.OVERCURRENT_X_FLAGS(fl[10:7]), .OVERCURRENT_Y_FLAGS(fl[6:3]),
		.OPEN_COIL_FLAGS(fl[2:1]), .CHARGE_PUMP_LOW(fl[0]),
		.FAULT_OUT_N_O(flt_o), .FAULT_OUT_N_OE(flt_oe),
		.WATCHDOG_ARM_BIT(arm), .WATCHDOG_INTERVAL(ivl),
		.WATCHDOG_KICK(kick), .WATCHDOG_FLAG_CLEAR(wclr),
		.CHARGE_PUMP_FAIL(cpf)
	);

	spi_host_model spi_host_model_inst (
		.sdo_line(sdo_line), .sclk(sclk), .sel_n(sel_n), .sdi(sdi),
		.rx(rx), .rx_done(rx_done)
	);

	task automatic conclude();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic report(input logic ok, input logic [31:0] e, g);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cmp_frame(input logic [15:0] e, g);
		report(g === e, 32'(e), 32'(g));
	endtask

	task automatic cmp_event(input logic [6:0] e, g);
		report(g === e, 32'(e), 32'(g));
	endtask

	task automatic cmp_pin(input logic e, g);
		report(g === e, 32'(e), 32'(g));
	endtask

	// Live status as the slave should shift it out
	function automatic logic [7:0] st0();
		return {1'b0, fl[12], ~cp_up | fl[0], 1'b0, fl[1], fl[2], 2'b00};
	endfunction

	task automatic xfer(input logic [7:0] c, t, e, input logic [15:0] m,
		input int n);
		rx_q.push_back({m, st0(), e});
		spi_host_model_inst.frame({c, t}, n);
		cmp_pin(1'b0, sdo_oe);
	endtask

	always @(posedge rx_done) begin
		if (rx_q.size() == 0)
			report(1'b0, 32'h0, 32'(rx));
		else begin
			rx_t = rx_q.pop_front();
			cmp_frame(rx_t[15:0] & rx_t[31:16], rx & rx_t[31:16]);
		end
	end

	// Pulse and register sampled mid-cycle, away from the launching edge
	always @(negedge CLOCK) begin
		if (kick === 1'b1 || wclr === 1'b1) begin
			if (ev_q.size() == 0)
				report(1'b0, 32'h0, 32'({kick, wclr}));
			else
				cmp_event(ev_q.pop_front(), {kick, wclr, arm, ivl});
		end
	end

	initial begin
		#1000000;
		num_errors++;
		conclude();
	end

	initial begin
		d = 8'($urandom(61805));
		repeat (3) @(posedge CLOCK);
		#1 RESETN = 1'b1;
		repeat (8) @(posedge CLOCK);
		cmp_pin(1'b1, cpf);
		cmp_pin(1'b1, flt_oe);
		repeat (60) @(posedge CLOCK);
		cp_up = 1'b1;
		cmp_pin(1'b0, cpf);
		xfer(8'h00, 8'h5a, 8'h00, 16'hffff, 16);
		for (int i = 0; i < 14; i++) begin
			@(posedge CLOCK) #1 fl = 13'h0001 << i;
			repeat (8) @(posedge CLOCK);
			cmp_pin(i < 13, flt_oe);
			cmp_pin(1'b0, flt_o);
			xfer(8'h04, 8'($urandom), st0(), 16'hffff, 16);
		end
		// Bits 6..5 of the command are set on the last write
		for (int k = 0; k < 6; k++) begin
			d = {k[0], 7'($urandom)} & WD_USED_MASK;
			ev_q.push_back({d[7], ~d[7], d[7], d[6:3]});
			xfer(k == 5 ? 8'he0 : 8'h80, d, 8'h00, 16'hff00, 16);
			xfer(8'h00, 8'($urandom), d, 16'hffff, 16);
		end
		xfer(8'h80, ~d, 8'h00, 16'h0000, 15);
		xfer(8'h80, ~d, 8'h00, 16'h0000, 17);
		xfer(8'h84, 8'hff, 8'h00, 16'hff00, 16);
		xfer(8'h04, 8'h00, st0(), 16'hffff, 16);
		xfer(8'h00, 8'h00, d, 16'hffff, 16);
		xfer(8'h1f, 8'h00, 8'h00, 16'hffff, 16);
		@(posedge CLOCK) #1 HARD_RESET_IN = 1'b1;
		repeat (5) @(posedge CLOCK);
		#1 HARD_RESET_IN = 1'b0;
		repeat (8) @(posedge CLOCK);
		cmp_event(7'h00, {2'b00, arm, ivl});
		xfer(8'h00, 8'h00, 8'h00, 16'hffff, 16);
		repeat (20) @(posedge CLOCK);
		cmp_pin(1'b1, rx_q.size() == 0 && ev_q.size() == 0);
		conclude();
	end
endmodule
